// ---- rtl/rail_seq_defines.vh ----
// timing and sequence constants for the three-rail power sequencer
`ifndef RAIL_SEQ_DEFINES_VH
`define RAIL_SEQ_DEFINES_VH
// clock rate in kHz (200 MHz)
`define CLK_KHZ 200000
// per-millisecond cycle count, derived from the rate
`define CYC_PER_MS (`CLK_KHZ)
// refresh interval on the first up and first down timer, in microseconds
`define REFRESH_US 400
`define REFRESH_CYC ((`REFRESH_US * `CLK_KHZ) / 1000)
// forced hold before power-down after an interrupted power-up, in ms
`define HOLD_MS 120
// standard timing options, in ms
`define OPT_MS_0 2
`define OPT_MS_1 10
`define OPT_MS_2 16
`define OPT_MS_3 30
`define OPT_MS_4 60
`define OPT_MS_5 120
// standard option delays as cycle counts at 200 MHz, sized to the counter
`define STD_CNT_0 25'h0061a80
`define STD_CNT_1 25'h01e8480
`define STD_CNT_2 25'h030d400
`define STD_CNT_3 25'h05b8d80
`define STD_CNT_4 25'h0b71b00
`define STD_CNT_5 25'h16e3600
// refresh interval and forced hold as cycle counts at 200 MHz
`define REFRESH_CNT 25'h0013880
`define HOLD_CNT 25'h16e3600
// default timing option code (16 ms) and sequence option
`define DEF_TIME_OPT 3'h2
`define DEF_SEQ_OPT 3'h1
// counter width, enough for 120.4 ms at 200 MHz
`define CNT_W 25
`endif

// ---- rtl/three_rail_power_sequencer.v ----
// three-rail power sequencer: enable-driven open-drain flag release and pull-down
//
// Contract
// - all three flags held low until enable is first asserted.
// - on enable, run first up timer; release flag one only when it expires.
// - flag one release starts timer two for flag two; flag two starts timer three.
// - three power-up delays held in separate, individually configurable timers; the code runs them on one shared counter.
// - enable low starts first down timer; flags pulled low in selected order.
// - three power-down delays in separate timers, independent of up timers; the code runs all six on one shared counter.
// - sequence option 1..6 picks down order; up order always 1-2-3.
// - default build uses sequence option 1, down order 3-2-1.
// - standard timing option sets all six delays to 2/10/16/30/60/120 ms.
// - delays within 15 percent, 20 percent for the 2 ms option.
// - flags are open drain: drive low when held, release otherwise.
// - enable loss before flag one resets timer one and returns to idle.
// - enable loss mid power-up finishes power-up, then waits 120 ms before down.
// - first up and first down timers add about 400 us refresh time.
`timescale 1ns/1ps
`include "rail_seq_defines.vh"

module three_rail_power_sequencer #(
    parameter [24:0] DLY1_CYC = `STD_CNT_2, // 16 ms each, per timer
    parameter [24:0] DLY2_CYC = `STD_CNT_2,
    parameter [24:0] DLY3_CYC = `STD_CNT_2,
    parameter [24:0] DLY4_CYC = `STD_CNT_2,
    parameter [24:0] DLY5_CYC = `STD_CNT_2,
    parameter [24:0] DLY6_CYC = `STD_CNT_2,
    parameter [24:0] REFRESH_CYC = `REFRESH_CNT,
    parameter [24:0] HOLD_CYC = `HOLD_CNT
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_enable,
    input wire i_use_std_timing,
    input wire [2:0] i_time_opt,
    input wire [2:0] i_seq_opt,
    input wire i_rail_release_first_in,
    input wire i_rail_release_second_in,
    input wire i_rail_release_third_in,
    output reg o_rail_release_first_out,
    output reg o_rail_release_first_oe_n,
    output reg o_rail_release_second_out,
    output reg o_rail_release_second_oe_n,
    output reg o_rail_release_third_out,
    output reg o_rail_release_third_oe_n,
    output reg [2:0] o_state
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
// o_state mirrors these codes one cycle late
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_UP = 3'h1;
localparam [2:0] ST_ON = 3'h2;
localparam [2:0] ST_HOLD = 3'h3;
localparam [2:0] ST_DOWN = 3'h4;

// ----------------------------------------------------------------
// enable synchroniser
// ----------------------------------------------------------------
reg en_meta;
reg en_sync;

// first stage feeds only the second
always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
        en_meta <= 1'b0;
        en_sync <= 1'b0;
    end else begin
        en_meta <= i_enable;
        en_sync <= en_meta;
    end
end

// ----------------------------------------------------------------
// option pin synchroniser
// ----------------------------------------------------------------
reg std_meta;
reg std_sync;
reg [2:0] time_meta;
reg [2:0] time_sync;
reg [2:0] seq_meta;
reg [2:0] seq_sync;

// option straps are pins too; bits may settle skewed, but the straps are
// quasi-static, so a two-stage register per bit is enough
always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
        std_meta <= 1'b0;
        std_sync <= 1'b0;
        time_meta <= `DEF_TIME_OPT;
        time_sync <= `DEF_TIME_OPT;
        seq_meta <= `DEF_SEQ_OPT;
        seq_sync <= `DEF_SEQ_OPT;
    end else begin
        std_meta <= i_use_std_timing;
        std_sync <= std_meta;
        time_meta <= i_time_opt;
        time_sync <= time_meta;
        seq_meta <= i_seq_opt;
        seq_sync <= seq_meta;
    end
end

// ----------------------------------------------------------------
// delay selection
// ----------------------------------------------------------------
reg [24:0] std_cyc;
reg [24:0] dly [0:5];
reg [2:0] seq;

// one common value for all six delays under a standard option
// unused option codes fall back to the 16 ms delay
always @* begin
    case (time_sync)
        3'h0: std_cyc = `STD_CNT_0;
        3'h1: std_cyc = `STD_CNT_1;
        3'h2: std_cyc = `STD_CNT_2;
        3'h3: std_cyc = `STD_CNT_3;
        3'h4: std_cyc = `STD_CNT_4;
        3'h5: std_cyc = `STD_CNT_5;
        default: std_cyc = `STD_CNT_2;
    endcase
end

// the clock is crystal-exact, so nominal counts sit well inside tolerance
// refresh is added only to slots 0 and 3 (first up, first down)
always @* begin
    if (std_sync) begin
        dly[0] = std_cyc + REFRESH_CYC;
        dly[1] = std_cyc;
        dly[2] = std_cyc;
        dly[3] = std_cyc + REFRESH_CYC;
        dly[4] = std_cyc;
        dly[5] = std_cyc;
    end else begin
        dly[0] = DLY1_CYC + REFRESH_CYC;
        dly[1] = DLY2_CYC;
        dly[2] = DLY3_CYC;
        dly[3] = DLY4_CYC + REFRESH_CYC;
        dly[4] = DLY5_CYC;
        dly[5] = DLY6_CYC;
    end
end

// out-of-range sequence option falls back to the standard 3-2-1 order
always @* begin
    if (seq_sync >= 3'h1 && seq_sync <= 3'h6)
        seq = seq_sync;
    else
        seq = `DEF_SEQ_OPT;
end

// flag index pulled low at down step 0..2 for each option
function [1:0] down_flag;
    input [2:0] opt;
    input [1:0] step;
    reg [5:0] ord;
    begin
        case (opt)
            3'h1: ord = {2'h0, 2'h1, 2'h2};
            3'h2: ord = {2'h1, 2'h0, 2'h2};
            3'h3: ord = {2'h0, 2'h2, 2'h1};
            3'h4: ord = {2'h2, 2'h0, 2'h1};
            3'h5: ord = {2'h1, 2'h2, 2'h0};
            3'h6: ord = {2'h2, 2'h1, 2'h0};
            default: ord = {2'h0, 2'h1, 2'h2};
        endcase
        case (step)
            2'h0: down_flag = ord[1:0];
            2'h1: down_flag = ord[3:2];
            default: down_flag = ord[5:4];
        endcase
    end
endfunction

// ----------------------------------------------------------------
// sequencing state machine
// ----------------------------------------------------------------
// step picks the timer slot; one counter suffices since only one timer runs
reg [2:0] state;
reg [1:0] step;
reg [24:0] cnt;
reg [2:0] released;
reg aborted;
reg [2:0] lock_seq;
reg [1:0] dflag;

// flag index pulled low at the current down step
always @* begin
    dflag = down_flag(lock_seq, step);
end

// one shared counter walks six timer slots on the one clock
always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
        state <= ST_IDLE;
        step <= 2'h0;
        cnt <= 25'h0;
        released <= 3'h0; // all flags low from reset
        aborted <= 1'b0;
        lock_seq <= `DEF_SEQ_OPT;
    end else begin
        case (state)
            ST_IDLE: begin
                released <= 3'h0;
                step <= 2'h0;
                cnt <= 25'h0;
                aborted <= 1'b0;
                if (en_sync)
                    state <= ST_UP;
            end
            ST_UP: begin
                if (!en_sync && step == 2'h0) begin
                    state <= ST_IDLE; // glitch before flag one: reset
                    cnt <= 25'h0;
                end else begin
                    // once aborted, enable is ignored until power-down ends
                    if (!en_sync && !aborted) begin
                        aborted <= 1'b1;
                        cnt <= 25'h0; // restart the running timer
                    end else if (cnt + 25'h1 >= dly[step]) begin
                        cnt <= 25'h0;
                        released[step] <= 1'b1;
                        if (step == 2'h2) begin
                            step <= 2'h0;
                            state <= aborted ? ST_HOLD : ST_ON;
                        end else begin
                            step <= step + 2'h1; // next timer chained
                        end
                    end else begin
                        cnt <= cnt + 25'h1;
                    end
                end
            end
            ST_ON: begin
                // order latched here, so a strap change mid-sequence is harmless
                cnt <= 25'h0;
                if (!en_sync) begin
                    lock_seq <= seq;
                    state <= ST_DOWN;
                end
            end
            ST_HOLD: begin
                // let rails settle before an interrupted cycle shuts down
                if (cnt + 25'h1 >= HOLD_CYC) begin
                    cnt <= 25'h0;
                    lock_seq <= seq;
                    state <= ST_DOWN;
                end else begin
                    cnt <= cnt + 25'h1;
                end
            end
            ST_DOWN: begin
                // down steps use slots 3..5, apart from the up timers
                if (cnt + 25'h1 >= dly[{1'b0, step} + 3'h3]) begin
                    cnt <= 25'h0;
                    released[dflag] <= 1'b0;
                    if (step == 2'h2) begin
                        step <= 2'h0;
                        state <= ST_IDLE;
                    end else begin
                        step <= step + 2'h1;
                    end
                end else begin
                    cnt <= cnt + 25'h1;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// open-drain pads
// ----------------------------------------------------------------
// pad readback inputs are left unused; the flags are not monitored
// out pins are tied low in the flop so a pad can never drive high
// drive low with enable low while held; release lets the pull-up win
always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
        o_rail_release_first_out <= 1'b0;
        o_rail_release_second_out <= 1'b0;
        o_rail_release_third_out <= 1'b0;
        o_rail_release_first_oe_n <= 1'b0;
        o_rail_release_second_oe_n <= 1'b0;
        o_rail_release_third_oe_n <= 1'b0;
        o_state <= ST_IDLE;
    end else begin
        o_rail_release_first_out <= 1'b0;
        o_rail_release_second_out <= 1'b0;
        o_rail_release_third_out <= 1'b0;
        o_rail_release_first_oe_n <= released[0];
        o_rail_release_second_oe_n <= released[1];
        o_rail_release_third_oe_n <= released[2];
        o_state <= state;
    end
end

endmodule

// ---- test/rail_seq_chk.sv ----
// concurrent checks on the three-rail power sequencer ports
`timescale 1ns/1ps
module rail_seq_chk #(
    parameter [24:0] DLY1_CYC = 25'h0000014,
    parameter [24:0] REFRESH_CYC = 25'h000000a
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_enable,
    input wire o_rail_release_first_out,
    input wire o_rail_release_second_out,
    input wire o_rail_release_third_out,
    input wire o_rail_release_first_oe_n,
    input wire o_rail_release_second_oe_n,
    input wire o_rail_release_third_oe_n,
    input wire [2:0] o_state
);
    wire [2:0] rel = {o_rail_release_third_oe_n, o_rail_release_second_oe_n,
        o_rail_release_first_oe_n};
    wire [2:0] outs = {o_rail_release_third_out, o_rail_release_second_out,
        o_rail_release_first_out};
    reg [24:0] up_cnt;
    // cycles spent in the up step, so the first release can be gauged
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            up_cnt <= 25'h0000000;
        end else if (o_state == 3'h1) begin
            up_cnt <= up_cnt + 25'h0000001;
        end else begin
            up_cnt <= 25'h0000000;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_IDLE_LOW: assert property (o_state == 3'h0 && $past(o_state) == 3'h0 |-> rel == 3'h0)
        else $error("flag released while idle");
    AST_OUT_LOW: assert property (outs == 3'h0)
        else $error("open drain output drives high");
    AST_SYNC_WAIT: assert property ($rose(i_enable) && o_state == 3'h0 |=> o_state == 3'h0)
        else $error("enable used before synchroniser");
    AST_UP_START: assert property ($rose(i_enable) && o_state == 3'h0 |-> ##[2:4] o_state == 3'h1)
        else $error("up step not entered");
    AST_FIRST_DELAY: assert property ($rose(o_rail_release_first_oe_n) |->
        up_cnt >= DLY1_CYC + REFRESH_CYC && up_cnt <= DLY1_CYC + REFRESH_CYC + 25'h3)
        else $error("first release at wrong time");
    AST_UP_ORDER: assert property (o_state == 3'h1 && rel[1] |-> rel[0] && (!rel[2] || rel[1]))
        else $error("up order broken");
    AST_ON_ALL: assert property (o_state == 3'h2 && $past(o_state) == 3'h2 |-> rel == 3'h7)
        else $error("flag low in on step");
    AST_HOLD_ALL: assert property (o_state == 3'h3 && $past(o_state) == 3'h3 |-> rel == 3'h7)
        else $error("flag low during hold");
    AST_DOWN_NO_RISE: assert property (o_state == 3'h4 |-> (rel & ~$past(rel)) == 3'h0)
        else $error("flag released during power down");
endmodule
bind three_rail_power_sequencer rail_seq_chk #(.DLY1_CYC(DLY1_CYC), .REFRESH_CYC(REFRESH_CYC))
    u_chk (.i_ref_clk, .i_rst, .i_enable, .o_rail_release_first_out, .o_rail_release_second_out,
    .o_rail_release_third_out, .o_rail_release_first_oe_n, .o_rail_release_second_oe_n,
    .o_rail_release_third_oe_n, .o_state);

// ---- test/rail_pullup_model.sv ----
// regulator enable lines with external pull-ups on the three flags
`timescale 1ns/1ps
module rail_pullup_model (
    input wire logic [2:0] i_out,
    input wire logic [2:0] i_oe_n,
    output logic [2:0] o_level
);
    // a released flag floats up; a driven one shows the pad value
    assign o_level = i_oe_n | i_out;
endmodule

// ---- test/tb_three_rail_power_sequencer.sv ----
// self-checking bench for the three-rail power sequencer
`timescale 1ns/1ps
module tb_three_rail_power_sequencer;
    // short, distinct delays, though with refresh the first up and first down timers last as long as the second ones
    localparam int D1 = 20, D2 = 30, D3 = 40, D4 = 25, D5 = 35, D6 = 45, RF = 10, HD = 50;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, std = 1'b0;
    logic [2:0] seq = 3'h1;
    wire [2:0] oen, outs, rail, st;
    int fail_count = 0, num_checks = 0, tm[3], a, b, c;
    logic [11:0] ord;
    initial begin
        forever #2.5 clk = ~clk;
    end
    three_rail_power_sequencer #(.DLY1_CYC(25'(D1)), .DLY2_CYC(25'(D2)), .DLY3_CYC(25'(D3)),
        .DLY4_CYC(25'(D4)), .DLY5_CYC(25'(D5)), .DLY6_CYC(25'(D6)), .REFRESH_CYC(25'(RF)),
        .HOLD_CYC(25'(HD))) i_three_rail_power_sequencer (.i_ref_clk(clk), .i_rst(rst),
        .i_enable(en), .i_use_std_timing(std), .i_time_opt(3'h0), .i_seq_opt(seq),
        .i_rail_release_first_in(rail[0]), .i_rail_release_second_in(rail[1]),
        .i_rail_release_third_in(rail[2]), .o_rail_release_first_out(outs[0]),
        .o_rail_release_first_oe_n(oen[0]), .o_rail_release_second_out(outs[1]),
        .o_rail_release_second_oe_n(oen[1]), .o_rail_release_third_out(outs[2]),
        .o_rail_release_third_oe_n(oen[2]), .o_state(st));
    rail_pullup_model i_rail_pullup_model (.i_out(outs), .i_oe_n(oen), .o_level(rail));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // records when and in which order the three lines reach lvl
    task automatic track(input logic lvl);
        logic [2:0] seen;
        seen = 3'h0;
        ord = 12'h000;
        for (int n = 1; n < 3000 && seen != 3'h7; n++) begin
            @(negedge clk);
            for (int k = 0; k < 3; k++) begin
                if (!seen[k] && rail[k] === lvl) begin
                    seen[k] = 1'b1;
                    tm[k] = n;
                    ord = {ord[7:0], 4'(k + 1)};
                end
            end
        end
        a = int'(ord[11:8]) - 1;
        b = int'(ord[7:4]) - 1;
        c = int'(ord[3:0]) - 1;
    endtask
    // spacing tolerates the sync and registered-output lag only
    task automatic gap(input int x, input int y, input int d);
        check(tm[y] - tm[x] >= d - 1 && tm[y] - tm[x] <= d + 2, 1'b1);
    endtask
    function automatic logic [11:0] dn_ord(input logic [2:0] o);
        case (o)
            3'h2: return 12'h312;
            3'h3: return 12'h231;
            3'h4: return 12'h213;
            3'h5: return 12'h132;
            3'h6: return 12'h123;
            default: return 12'h321;
        endcase
    endfunction
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        cyc(20000);
        fail_count++;
        finish_test;
    end
    initial begin
        cyc(5);
        rst = 1'b0;
        cyc(40);
        check(rail, 3'h0);
        en = 1'b1;
        cyc(10);
        en = 1'b0;
        cyc(D1 + 20);
        check({st, rail}, 6'h00);
        $display("test glitch done");
        // standard 2 ms option: no flag may rise within 200 cycles
        std = 1'b1;
        en = 1'b1;
        cyc(200);
        check({st, rail}, 6'h08);
        en = 1'b0;
        std = 1'b0;
        cyc(10);
        check({st, rail}, 6'h00);
        $display("test standard timing done");
        for (int o = 0; o < 8; o++) begin
            seq = 3'(o);
            en = 1'b1;
            track(1'b1);
            check(ord, 12'h123);
            check(tm[0] >= D1 + RF + 2 && tm[0] <= D1 + RF + 6, 1'b1);
            gap(0, 1, D2);
            gap(1, 2, D3);
            en = 1'b0;
            track(1'b0);
            check(ord, dn_ord(seq));
            check(tm[a] >= D4 + RF + 2 && tm[a] <= D4 + RF + 7, 1'b1);
            gap(a, b, D5);
            gap(b, c, D6);
            cyc(3);
            check(st, 3'h0);
            $display("test order option %0d done", o);
        end
        en = 1'b1;
        for (int k = 0; k < 200 && rail[0] !== 1'b1; k++) begin
            @(negedge clk);
        end
        en = 1'b0;
        track(1'b1);
        check(ord, 12'h123);
        track(1'b0);
        check(tm[a] >= HD + D4 + RF, 1'b1);
        $display("test interrupted power-up done");
        finish_test;
    end
endmodule
